/* File: design/sblc_pkg.sv */
// ==========================================================================
// shared constants and types
package sblc_pkg;

  localparam int unsigned PORT_W        = 3;
  localparam int unsigned TAG_W         = 8;
  localparam int unsigned DEF_NPORTS    = 8;
  localparam int unsigned DEF_UP_PORT   = 0;
  localparam int unsigned DEF_FIFO_DEPTH = 32;
  localparam int unsigned DEF_PEND_W    = 6;
  localparam logic [PORT_W-1:0] LOCK_PORT_RST = 3'h0;

  typedef enum logic [3:0] {
    KD_MWR    = 4'h0,
    KD_MRD    = 4'h1,
    KD_MRDLK  = 4'h2,
    KD_CPL    = 4'h3,
    KD_CPLD   = 4'h4,
    KD_CPLLK  = 4'h5,
    KD_CPLDLK = 4'h6,
    KD_MSG    = 4'h7,
    KD_UNLOCK = 4'h8,
    KD_CFG    = 4'h9
  } sblc_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE       = 2'b00,
    ST_DN_LOCKED  = 2'b01,
    ST_BUS_LOCKED = 2'b10
  } sblc_state_t;

  typedef struct packed {
    logic [TAG_W-1:0]  tag;
    logic              vc0;
    sblc_kind_t        kind;
    logic [PORT_W-1:0] dst;
    logic [PORT_W-1:0] src;
  } sblc_desc_t;

endpackage

/* File: design/sblc_lock_if.sv */
`timescale 1ns/1ps
// ==========================================================================
// forwarding events toward the lock state machine, lock state back
interface sblc_lock_if;
  import sblc_pkg::*;
  logic                 ev_valid;
  sblc_kind_t           ev_kind;
  logic [PORT_W-1:0]    ev_src;
  logic [PORT_W-1:0]    ev_dst;
  sblc_state_t          state;
  logic [PORT_W-1:0]    lock_port;
  logic                 dn_locked;
  logic                 up_locked;
  logic                 bus_locked;

  modport fsm  (input ev_valid, ev_kind, ev_src, ev_dst,
                output state, lock_port, dn_locked, up_locked, bus_locked);
  modport user (output ev_valid, ev_kind, ev_src, ev_dst,
                input state, lock_port, dn_locked, up_locked, bus_locked);
endinterface

/* File: design/sblc_fifo.sv */
`timescale 1ns/1ps
// ==========================================================================
// synchronous fifo, valid/ready on both sides
module sblc_fifo #(
  parameter int unsigned W     = 19,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("sblc_fifo depth must be a power of two, at least 2");
  end

  logic [W-1:0]  mem [DEPTH];
  logic [AW:0]   wp_r;
  logic [AW:0]   wp_nxt;
  logic [AW:0]   rp_r;
  logic [AW:0]   rp_nxt;
  logic          push;
  logic          pop;

  assign o_in_ready  = (wp_r[AW] == rp_r[AW]) || (wp_r[AW-1:0] != rp_r[AW-1:0]);
  assign o_out_valid = (wp_r != rp_r);
  assign o_out_data  = mem[rp_r[AW-1:0]];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb begin
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  // storage needs no reset; only the pointers say what is valid
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= i_in_data;
    end
  end
endmodule

/* File: design/sblc_lock_fsm.sv */
`timescale 1ns/1ps
// ==========================================================================
// partition lock state
module sblc_lock_fsm
  import sblc_pkg::*;
#(
  parameter logic [PORT_W-1:0] UP_PORT = PORT_W'(DEF_UP_PORT)
) (
  input  wire logic   i_clk,
  input  wire logic   i_rst_n,
  sblc_lock_if.fsm    lk
);
  sblc_state_t        state_r;
  sblc_state_t        state_nxt;
  logic [PORT_W-1:0]  port_r;
  logic [PORT_W-1:0]  port_nxt;

  always_comb begin
    state_nxt = state_r;
    port_nxt  = port_r;
    unique case (state_r)
      ST_IDLE: begin
        // a second lock can never start: only idle accepts one
        if (lk.ev_valid && lk.ev_kind == KD_MRDLK && lk.ev_src == UP_PORT) begin
          state_nxt = ST_DN_LOCKED;
          port_nxt  = lk.ev_dst;
        end
      end
      ST_DN_LOCKED: begin
        if (lk.ev_valid && lk.ev_kind == KD_UNLOCK) begin
          state_nxt = ST_IDLE;
        end else if (lk.ev_valid && lk.ev_kind == KD_CPLDLK && lk.ev_src == port_r) begin
          state_nxt = ST_BUS_LOCKED;
        end
      end
      ST_BUS_LOCKED: begin
        // further locked reads, completions and writes leave it alone
        if (lk.ev_valid && lk.ev_kind == KD_UNLOCK) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
      port_r  <= LOCK_PORT_RST;
    end else begin
      state_r <= state_nxt;
      port_r  <= port_nxt;
    end
  end

  assign lk.state      = state_r;
  assign lk.lock_port  = port_r;
  assign lk.dn_locked  = (state_r != ST_IDLE);
  assign lk.up_locked  = (state_r == ST_BUS_LOCKED);
  assign lk.bus_locked = (state_r == ST_BUS_LOCKED);

  a_lock_port_stable: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_r != ST_IDLE && $past(state_r) != ST_IDLE) |-> $stable(port_r))
    else $error("lock port changed while locked");

  a_reset_clears: assert property (
    @(posedge i_clk) $past(i_rst_n) == 1'b0 |-> state_r == ST_IDLE)
    else $error("lock survived reset");
endmodule

/* File: design/sblc_top.sv */
`timescale 1ns/1ps
// ==========================================================================
// bus lock controller for one switch partition
//
// Function
// - one lock per partition, upstream to one downstream
// - locked read forwarded, then target port locked
// - blocking only for tlps mapped to vc0
// - locked read waits for queued posted requests
// - traffic toward other ports keeps flowing
// - locked completion forwarded, then upstream locked
// - locked completion waits for queued posted requests
// - bus-locked after completion until unlock
// - sideband register access still served while locked
// - further locked reads and completions keep lock
// - memory writes pass without changing lock
// - locked ports may still originate messages
// - unlock releases ports, forwarded, frees held traffic
// - unlock waits for posted requests from upstream
// - unlock at unlocked port is ignored
// - blocked tlps held until unlock, never dropped
module sblc_top
  import sblc_pkg::*;
#(
  parameter int unsigned       NPORTS     = DEF_NPORTS,
  parameter logic [PORT_W-1:0] UP_PORT    = PORT_W'(DEF_UP_PORT),
  parameter int unsigned       FIFO_DEPTH = DEF_FIFO_DEPTH,
  parameter int unsigned       PEND_W     = DEF_PEND_W
) (
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_in_valid,
  output logic                    o_in_ready,
  input  wire logic [PORT_W-1:0]  i_in_src,
  input  wire logic [PORT_W-1:0]  i_in_dst,
  input  wire sblc_kind_t         i_in_kind,
  input  wire logic               i_in_vc0,
  input  wire logic [TAG_W-1:0]   i_in_tag,
  output logic                    o_fwd_valid,
  input  wire logic               i_fwd_ready,
  output logic [PORT_W-1:0]       o_fwd_src,
  output logic [PORT_W-1:0]       o_fwd_dst,
  output sblc_kind_t              o_fwd_kind,
  output logic                    o_fwd_vc0,
  output logic [TAG_W-1:0]        o_fwd_tag,
  input  wire logic [NPORTS-1:0]  i_posted_done,
  output logic                    o_bus_locked,
  output logic                    o_dn_locked,
  output logic                    o_up_locked,
  output logic [PORT_W-1:0]       o_lock_port
);
  localparam int unsigned DW = $bits(sblc_desc_t);

  if (NPORTS < 2 || NPORTS > (1 << PORT_W) || UP_PORT >= NPORTS || PEND_W < 1)
  begin : g_chk
    $error("sblc_top parameters out of range");
  end

  // ========================================================================
  // queues: arrival order, and the holding pen for lock-blocked tlps
  sblc_desc_t  in_desc;
  sblc_desc_t  iq_data;
  sblc_desc_t  hq_data;
  logic        iq_valid;
  logic        iq_ready;
  logic        hq_in_ready;
  logic        hq_valid;
  logic        hq_ready;
  logic        take_fwd;
  logic        take_hold;
  logic        take_drop;

  always_comb begin
    in_desc      = '0;
    in_desc.src  = i_in_src;
    in_desc.dst  = i_in_dst;
    in_desc.kind = i_in_kind;
    in_desc.vc0  = i_in_vc0;
    in_desc.tag  = i_in_tag;
  end

  sblc_fifo #(
    .W     (DW),
    .DEPTH (FIFO_DEPTH)
  ) u_in_q (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (i_in_valid),
    .o_in_ready  (o_in_ready),
    .i_in_data   (in_desc),
    .o_out_valid (iq_valid),
    .i_out_ready (iq_ready),
    .o_out_data  (iq_data)
  );

  // a full pen stalls the arrival queue instead of losing a tlp
  sblc_fifo #(
    .W     (DW),
    .DEPTH (FIFO_DEPTH)
  ) u_hold_q (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (take_hold),
    .o_in_ready  (hq_in_ready),
    .i_in_data   (iq_data),
    .o_out_valid (hq_valid),
    .i_out_ready (hq_ready),
    .o_out_data  (hq_data)
  );

  // ========================================================================
  // lock state
  sblc_lock_if lk ();

  sblc_lock_fsm #(
    .UP_PORT (UP_PORT)
  ) u_fsm (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .lk      (lk)
  );

  // ========================================================================
  // head selection and lock gate
  logic              use_hold;
  logic              head_valid;
  sblc_desc_t        head;
  logic              blocked;
  logic              special;
  logic              posted;
  logic [PORT_W-1:0] eff_dst;
  logic              out_valid_r;
  logic              out_valid_nxt;
  sblc_desc_t        out_r;
  sblc_desc_t        out_nxt;
  logic              out_free;
  logic              order_ok;
  logic [NPORTS-1:0] pend_zero;
  logic [NPORTS-1:0] pend_full;

  // held tlps go first once the partition is free again
  assign use_hold   = hq_valid && (lk.state == ST_IDLE);
  assign head_valid = use_hold ? hq_valid : iq_valid;
  assign head       = use_hold ? hq_data : iq_data;

  // only egress toward a locked port is gated; messages and msis that the
  // locked ports originate are exempt by source and pass
  always_comb begin
    blocked = 1'b0;
    if (head.vc0) begin
      if (lk.dn_locked && head.dst == lk.lock_port && head.src != UP_PORT) begin
        blocked = 1'b1;
      end
      if (lk.up_locked && head.dst == UP_PORT && head.src != lk.lock_port) begin
        blocked = 1'b1;
      end
    end
  end

  assign special = (head.kind == KD_MRDLK) || (head.kind == KD_CPLDLK) ||
                   (head.kind == KD_UNLOCK);
  assign posted  = (head.kind == KD_MWR) || (head.kind == KD_MSG) ||
                   (head.kind == KD_UNLOCK);
  // unlock goes only to the port that holds the lock
  assign eff_dst = (head.kind == KD_UNLOCK) ? lk.lock_port : head.dst;

  assign out_free = !out_valid_r || i_fwd_ready;
  // lock-ordered tlps leave only after every earlier posted tlp to that egress
  // has left and the out stage is empty; completions and non-posted requests are not counted
  assign order_ok = !special || (!out_valid_r && pend_zero[eff_dst]);

  assign take_drop = head_valid && head.kind == KD_UNLOCK &&
                     (lk.state == ST_IDLE || head.src != UP_PORT);
  assign take_fwd  = head_valid && !blocked && !take_drop && out_free && order_ok &&
                     !(posted && pend_full[eff_dst]);
  assign take_hold = head_valid && blocked && !use_hold && hq_in_ready;
  assign iq_ready  = !use_hold && (take_fwd || take_hold || take_drop);
  assign hq_ready  = use_hold && (take_fwd || take_drop);

  assign lk.ev_valid = take_fwd;
  assign lk.ev_kind  = head.kind;
  assign lk.ev_src   = head.src;
  assign lk.ev_dst   = eff_dst;

  // ========================================================================
  // registered forward stage
  always_comb begin
    out_valid_nxt = out_valid_r;
    out_nxt       = out_r;
    if (take_fwd) begin
      out_valid_nxt = 1'b1;
      out_nxt       = head;
      out_nxt.dst   = eff_dst;
    end else if (i_fwd_ready) begin
      out_valid_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      out_valid_r <= 1'b0;
      out_r       <= '0;
    end else begin
      out_valid_r <= out_valid_nxt;
      out_r       <= out_nxt;
    end
  end

  assign o_fwd_valid = out_valid_r;
  assign o_fwd_src   = out_r.src;
  assign o_fwd_dst   = out_r.dst;
  assign o_fwd_kind  = out_r.kind;
  assign o_fwd_vc0   = out_r.vc0;
  assign o_fwd_tag   = out_r.tag;

  // ========================================================================
  // posted tlps issued per egress and not yet sent by the fabric
  for (genvar p = 0; p < NPORTS; p++) begin : g_pend
    logic [PEND_W-1:0] cnt_r;
    logic [PEND_W-1:0] cnt_nxt;
    logic              inc;
    logic              dec;

    assign inc = take_fwd && posted && (eff_dst == PORT_W'(p));
    assign dec = i_posted_done[p] && (cnt_r != '0);

    // counter saturates; a full counter stalls further posted issue
    always_comb begin
      cnt_nxt = cnt_r;
      if (inc && !dec) begin
        cnt_nxt = cnt_r + 1'b1;
      end else if (dec && !inc) begin
        cnt_nxt = cnt_r - 1'b1;
      end
    end

    always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_nxt;
      end
    end

    assign pend_zero[p] = (cnt_r == '0);
    assign pend_full[p] = (cnt_r == '1);
  end

  // the sideband register path never passes this gate, so it keeps working
  // while config accesses from the root are not allowed
  assign o_bus_locked = lk.bus_locked;
  assign o_dn_locked  = lk.dn_locked;
  assign o_up_locked  = lk.up_locked;
  assign o_lock_port  = lk.lock_port;

  // ========================================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_lkrd_taken;
    take_fwd && head.kind == KD_MRDLK && head.src == UP_PORT && lk.state == ST_IDLE;
  endsequence

  sequence s_cpl_taken;
    take_fwd && head.kind == KD_CPLDLK && lk.state == ST_DN_LOCKED &&
    head.src == lk.lock_port;
  endsequence

  sequence s_unlock_taken;
    take_fwd && head.kind == KD_UNLOCK;
  endsequence

  a_lkrd_locks_dn: assert property (
    s_lkrd_taken |=> lk.dn_locked && lk.lock_port == $past(head.dst) &&
                     o_fwd_valid && o_fwd_kind == KD_MRDLK)
    else $error("locked read did not lock its target");

  a_nonvc0_passes: assert property (
    head_valid && !head.vc0 |-> !blocked)
    else $error("non-vc0 tlp was blocked");

  a_lkrd_after_posted: assert property (
    take_fwd && head.kind == KD_MRDLK |-> pend_zero[eff_dst] && !out_valid_r)
    else $error("locked read overtook posted traffic");

  a_other_ports_flow: assert property (
    head_valid && head.dst != lk.lock_port && head.dst != UP_PORT |-> !blocked)
    else $error("traffic to an unlocked port was blocked");

  a_cpl_locks_bus: assert property (
    s_cpl_taken |=> lk.up_locked ##0 o_bus_locked ##0 o_fwd_dst == UP_PORT)
    else $error("locked completion did not lock upstream");

  a_cpl_after_posted: assert property (
    take_fwd && head.kind == KD_CPLDLK |-> pend_zero[UP_PORT])
    else $error("locked completion overtook posted traffic");

  a_lock_persists: assert property (
    o_bus_locked && !take_fwd |=> o_bus_locked)
    else $error("bus lock dropped without unlock");

  a_lock_kept_cpl: assert property (
    o_bus_locked && take_fwd && head.kind != KD_UNLOCK |=> o_bus_locked && $stable(o_lock_port))
    else $error("locked traffic changed the lock");

  a_unlock_release: assert property (
    s_unlock_taken |=> !o_dn_locked && !o_up_locked && o_fwd_kind == KD_UNLOCK &&
                       o_fwd_dst == $past(lk.lock_port))
    else $error("unlock did not release the partition");

  a_unlock_drain: assert property (
    s_unlock_taken |-> pend_zero[lk.lock_port] && !out_valid_r)
    else $error("unlock overtook posted traffic");

  a_unlock_ignored: assert property (
    take_drop |=> $stable(lk.state) && (!o_fwd_valid || $past(out_valid_r)))
    else $error("ignored unlock changed state");

  a_blocked_kept: assert property (
    head_valid && blocked && !use_hold |-> take_hold || !iq_ready)
    else $error("blocked tlp discarded");
endmodule

/* File: sim/sblc_fabric_model.sv */
`timescale 1ns/1ps
// ==========================================================================
// egress fabric beyond the forwarding output: accepts, stalls, reports posted
module sblc_fabric_model
  import sblc_pkg::*;
#(
  parameter int unsigned NPORTS = DEF_NPORTS
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_slow,
  input  wire logic              i_fwd_valid,
  input  wire logic [PORT_W-1:0] i_fwd_dst,
  input  wire sblc_kind_t        i_fwd_kind,
  output logic                   o_fwd_ready,
  output logic [NPORTS-1:0]      o_posted_done
);
  logic [7:0] lfsr_r;

  // stalls are pseudo random so queues really build up behind the out stage
  assign o_fwd_ready = !(i_slow && lfsr_r[0]);

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      lfsr_r        <= 8'h5a;
      o_posted_done <= '0;
    end else begin
      lfsr_r        <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
      o_posted_done <= '0;
      // one pulse per posted tlp sent out, so ordering waits can end
      if (i_fwd_valid && o_fwd_ready &&
          (i_fwd_kind == KD_MWR || i_fwd_kind == KD_MSG || i_fwd_kind == KD_UNLOCK)) begin
        o_posted_done[i_fwd_dst] <= 1'b1;
      end
    end
  end
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
// ==========================================================================
// self-checking bench for the partition lock controller
module tb_top;
  import sblc_pkg::*;
  localparam int NP = 8;
  localparam int UP = 0;

  logic              i_clk       = 1'b0;
  logic              i_rst_n     = 1'b0;
  logic              i_in_valid  = 1'b0;
  logic [PORT_W-1:0] i_in_src    = 3'h0;
  logic [PORT_W-1:0] i_in_dst    = 3'h0;
  sblc_kind_t        i_in_kind   = KD_MWR;
  logic              i_in_vc0    = 1'b0;
  logic [TAG_W-1:0]  i_in_tag    = 8'h00;
  logic              i_slow      = 1'b0;
  logic              o_in_ready, o_fwd_valid, i_fwd_ready, o_fwd_vc0;
  logic [PORT_W-1:0] o_fwd_src, o_fwd_dst, o_lock_port;
  sblc_kind_t        o_fwd_kind;
  logic [TAG_W-1:0]  o_fwd_tag;
  logic [NP-1:0]     i_posted_done;
  logic              o_bus_locked, o_dn_locked, o_up_locked;
  sblc_desc_t        got[$];
  sblc_desc_t        sent[256];
  logic [TAG_W-1:0]  rt[$];
  logic              rh[$];
  logic [TAG_W-1:0]  tag_cnt     = 8'h00;
  int                n_errors    = 0;
  int                num_checks  = 0;
  int                cycles      = 0;
  sblc_kind_t        kinds[6]    = '{KD_MWR, KD_MRD, KD_CPL, KD_CPLD, KD_MSG, KD_CFG};

  always #50 i_clk = ~i_clk;

  sblc_top #(.NPORTS(NP), .UP_PORT(3'h0), .FIFO_DEPTH(32), .PEND_W(6)) dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_in_valid(i_in_valid), .o_in_ready(o_in_ready),
    .i_in_src(i_in_src), .i_in_dst(i_in_dst), .i_in_kind(i_in_kind), .i_in_vc0(i_in_vc0),
    .i_in_tag(i_in_tag), .o_fwd_valid(o_fwd_valid), .i_fwd_ready(i_fwd_ready),
    .o_fwd_src(o_fwd_src), .o_fwd_dst(o_fwd_dst), .o_fwd_kind(o_fwd_kind),
    .o_fwd_vc0(o_fwd_vc0), .o_fwd_tag(o_fwd_tag), .i_posted_done(i_posted_done),
    .o_bus_locked(o_bus_locked), .o_dn_locked(o_dn_locked), .o_up_locked(o_up_locked),
    .o_lock_port(o_lock_port));

  sblc_fabric_model #(.NPORTS(NP)) fab (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_slow(i_slow), .i_fwd_valid(o_fwd_valid),
    .i_fwd_dst(o_fwd_dst), .i_fwd_kind(o_fwd_kind), .o_fwd_ready(i_fwd_ready),
    .o_posted_done(i_posted_done));

  task automatic end_sim();
    $display("checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (i_rst_n && o_fwd_valid === 1'b1 && i_fwd_ready === 1'b1) begin
      got.push_back(sblc_desc_t'{tag: o_fwd_tag, vc0: o_fwd_vc0, kind: o_fwd_kind,
                                 dst: o_fwd_dst, src: o_fwd_src});
    end
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  function automatic int pos(input logic [TAG_W-1:0] t);
    foreach (got[i]) if (got[i].tag === t) return i;
    return -1;
  endfunction

  // a tlp waits for unlock only on vc0, toward a locked port, from a foreign port
  function automatic logic held(input int s, input int d, input logic v, input int lk,
                                input logic up);
    return v && s != UP && (d == lk || (up && d == UP && s != lk));
  endfunction

  task automatic send(input int s, input int d, input sblc_kind_t k, input logic v,
                      output logic [TAG_W-1:0] t);
    logic ok;
    @(negedge i_clk);
    t          = tag_cnt;
    tag_cnt    = tag_cnt + 8'h01;
    i_in_valid = 1'b1;
    i_in_src   = s[PORT_W-1:0];
    i_in_dst   = d[PORT_W-1:0];
    i_in_kind  = k;
    i_in_vc0   = v;
    i_in_tag   = t;
    sent[t]    = sblc_desc_t'{tag: t, vc0: v, kind: k, dst: i_in_dst, src: i_in_src};
    forever begin
      ok = o_in_ready;
      @(posedge i_clk);
      if (ok === 1'b1) break;
      @(negedge i_clk);
    end
  endtask

  task automatic idle(input int n);
    @(negedge i_clk);
    i_in_valid = 1'b0;
    repeat (n) @(posedge i_clk);
  endtask

  task automatic wait_tag(input logic [TAG_W-1:0] t);
    int n;
    // drop the request first, or the last tlp is taken again every cycle
    @(negedge i_clk);
    i_in_valid = 1'b0;
    n = 0;
    while (pos(t) < 0 && n < 200) begin
      @(posedge i_clk);
      n++;
    end
    check(pos(t) >= 0, 1, "tlp never forwarded");
  endtask

  // traffic from any port while unlocked, else from the other downstream ports; config kept out while locked
  task automatic burst(input int lk, input logic up, input int nk, input int n);
    logic [TAG_W-1:0] t;
    int               s;
    int               d;
    logic             v;
    repeat (n) begin
      do s = $urandom_range(NP - 1); while ((lk >= 0 && s == UP) || s == lk);
      do d = $urandom_range(NP - 1); while (d == s);
      v = $urandom_range(1);
      send(s, d, kinds[$urandom_range(nk)], v, t);
      rt.push_back(t);
      rh.push_back(held(s, d, v, lk, up));
    end
  endtask

  initial begin
    logic [TAG_W-1:0] t, tw, tl, tu, ta, tb, tc, td, te;
    int               lk;
    int               n;
    n = $urandom(90);
    repeat (10) @(posedge i_clk);
    @(negedge i_clk);
    i_rst_n = 1'b1;
    check({o_bus_locked, o_dn_locked, o_up_locked, o_fwd_valid}, 0, "reset locks");
    check({o_lock_port, o_in_ready}, 1, "reset port");
    for (int it = 0; it < 3; it++) begin
      lk     = 1 + $urandom_range(NP - 2);
      i_slow = it[0];
      rt.delete();
      rh.delete();
      send(UP, lk, KD_UNLOCK, 1'b1, tu);
      idle(10);
      check(pos(tu) < 0, 1, "idle unlock forwarded");
      check({o_dn_locked, o_bus_locked}, 0, "idle unlock state");
      burst(-1, 1'b0, 5, 8);
      send(UP, lk, KD_MWR, 1'b1, tw);
      send(UP, lk, KD_MRDLK, 1'b1, tl);
      wait_tag(tl);
      check(pos(tw) >= 0 && pos(tw) < pos(tl), 1, "posted before locked read");
      check(got[pos(tl)].dst, lk, "locked read target");
      idle(2);
      check({o_dn_locked, o_bus_locked}, 2'b10, "down lock");
      check(o_lock_port, lk, "lock port");
      burst(lk, 1'b0, 4, 8);
      send(lk, UP, KD_MWR, 1'b1, tw);
      send(lk, UP, KD_CPLDLK, 1'b1, tl);
      wait_tag(tl);
      check(pos(tw) >= 0 && pos(tw) < pos(tl), 1, "posted before locked cpl");
      idle(2);
      check({o_up_locked, o_bus_locked, o_dn_locked}, 3'b111, "bus lock");
      burst(lk, 1'b1, 4, 8);
      send(lk, UP, KD_MSG, 1'b1, ta);
      send(UP, lk, KD_MRDLK, 1'b1, tb);
      send(lk, UP, KD_CPLLK, 1'b1, tc);
      send(UP, lk, KD_MWR, 1'b1, td);
      send(lk, UP, KD_CPLDLK, 1'b1, te);
      send(1 + (lk % (NP - 1)), lk, KD_UNLOCK, 1'b0, t);
      idle(30);
      check(pos(ta) >= 0 && pos(tb) >= 0 && pos(tc) >= 0, 1,
            "locked traffic");
      check(pos(td) >= 0 && pos(te) >= 0, 1, "locked write and cpl");
      check(pos(t) < 0, 1, "foreign unlock forwarded");
      check({o_bus_locked, o_up_locked, o_dn_locked}, 3'b111,
            "still locked");
      check(o_lock_port, lk, "lock port kept");
      if (it == 2) begin
        @(negedge i_clk);
        i_rst_n = 1'b0;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        i_rst_n = 1'b1;
        check({o_bus_locked, o_dn_locked, o_up_locked, o_lock_port}, 0, "mid reset");
        n = got.size();
        idle(20);
        check(got.size(), n, "held traffic after reset");
      end else begin
        send(UP, lk, KD_MWR, 1'b1, tw);
        send(UP, lk, KD_UNLOCK, 1'b1, tu);
        wait_tag(tu);
        check(pos(tw) >= 0 && pos(tw) < pos(tu), 1, "posted before unlock");
        check(got[pos(tu)].dst, lk, "unlock target");
        idle(2);
        check({o_bus_locked, o_up_locked, o_dn_locked}, 0, "unlocked");
        idle(60);
        foreach (rt[i]) begin
          check(pos(rt[i]) >= 0, 1, "tlp lost");
          check(pos(rt[i]) > pos(tu), rh[i],
                "held vs passed");
        end
      end
    end
    foreach (got[i]) check(got[i], sent[got[i].tag], "fields changed");
    end_sim();
  end
endmodule
